// ===== common/mcu_ctrl_pkg.sv
/*
  Constants and carrier types for the branch and machine-cycle unit:
  tick positions inside a machine cycle, opcode encodings, reset values.
  Assumes the oscillator clock drives sys_clk directly, one tick per period.
*/
package mcu_ctrl_pkg;

  // Machine cycle: 6 states of 2 oscillator periods each
  localparam int unsigned STATES_PER_CYCLE = 6;
  localparam int unsigned TICKS_PER_STATE  = 2;
  localparam int unsigned TICKS_PER_CYCLE  = STATES_PER_CYCLE * TICKS_PER_STATE;
  localparam logic [3:0]  LAST_TICK        = 4'(TICKS_PER_CYCLE - 1);
  localparam logic [2:0]  FIRST_STATE      = 3'h1;

  // Fetch slots: strobe in S1 phase 1 and S4 phase 1, byte sampled one tick later,
  // so the opcode lands before S1 ends and the second byte before S4 ends
  localparam logic [3:0]  FETCH1_TICK      = 4'h0;
  localparam logic [3:0]  FETCH2_TICK      = 4'h6;
  localparam logic [3:0]  SAMPLE1_TICK     = 4'h1;
  localparam logic [3:0]  SAMPLE2_TICK     = 4'h7;

  localparam logic [15:0] PC_RESET         = 16'h0000;
  localparam int unsigned STACK_DEPTH      = 8;
  localparam logic [2:0]  SP_RESET         = 3'h0;

  // Opcode encodings
  localparam logic [7:0]  OP_NO_OPERATION  = 8'h00;
  localparam logic [7:0]  OP_LONG_JUMP     = 8'h02;
  localparam logic [7:0]  OP_LONG_CALL     = 8'h12;
  localparam logic [7:0]  OP_SUB_RETURN    = 8'h22;
  localparam logic [7:0]  OP_INT_RETURN    = 8'h32;
  localparam logic [7:0]  OP_ACC_ZERO      = 8'h60;
  localparam logic [7:0]  OP_ACC_NONZERO   = 8'h70;
  localparam logic [7:0]  OP_INDEXED_JUMP  = 8'h73;
  localparam logic [7:0]  OP_SHORT_JUMP    = 8'h80;
  localparam logic [7:0]  OP_COMPARE_BR    = 8'hb4;
  localparam logic [7:0]  OP_DECREMENT_BR  = 8'hd8;
  localparam logic [7:0]  OP_XDATA_MOVE    = 8'he0;
  // Absolute forms: top 3 opcode bits are target bits 10:8
  localparam logic [4:0]  OP_ABS_JUMP_LOW  = 5'h01;
  localparam logic [4:0]  OP_ABS_CALL_LOW  = 5'h11;

  typedef enum logic [3:0] {
    K_NO_OPERATION,
    K_SHORT_JUMP,
    K_LONG_JUMP,
    K_ABS_JUMP,
    K_LONG_CALL,
    K_ABS_CALL,
    K_SUB_RETURN,
    K_INT_RETURN,
    K_ACC_ZERO,
    K_ACC_NONZERO,
    K_INDEXED_JUMP,
    K_DECREMENT_BR,
    K_COMPARE_BR,
    K_XDATA_MOVE,
    K_OTHER
  } kind_e;

  typedef struct packed {
    logic [2:0] state;    // 1..6
    logic       phase1;   // 1 in first half of the state
    logic [3:0] tick;     // 0..11
  } timing_s;

  typedef struct packed {
    logic [7:0]  acc;
    logic [15:0] data_pointer_register;
    logic [7:0]  opnd_a;
    logic [7:0]  opnd_b;
  } operand_s;

  typedef struct packed {
    logic       dec_we;
    logic [7:0] dec_value;
    logic       carry_we;
    logic       carry;
    logic       irq_done;
  } result_s;

endpackage

// ===== logic/cycle_timing_gen.sv
/*
  Machine-cycle timing generator: counts oscillator periods into six states,
  each split into two phases.
  Assumes sys_clk is the oscillator clock itself.
*/
`timescale 1ns/10ps
`default_nettype none

module cycle_timing_gen (
  input  wire logic                  sys_clk, // Oscillator clock
  input  wire logic                  rstn,    // Async reset, active low
  output mcu_ctrl_pkg::timing_s      timing   // State, phase and tick
);
  import mcu_ctrl_pkg::*;

  typedef struct packed {
    logic [3:0] tick;
  } gen_s;

  gen_s q;
  gen_s d;

  always_comb begin
    d = q;
    if (q.tick == LAST_TICK) begin
      d.tick = 4'h0;
    end else begin
      d.tick = q.tick + 4'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Two ticks per state: even tick is phase 1, odd tick is phase 2
  assign timing.tick   = q.tick;
  assign timing.state  = q.tick[3:1] + FIRST_STATE;
  assign timing.phase1 = ~q.tick[0];

endmodule

`default_nettype wire

// ===== logic/branch_cycle_unit.sv
/*
  Branch and machine-cycle unit: fetches code bytes twice per machine cycle (none in a data move's second),
  decodes the control-flow instructions and updates the program counter.
  Assumes code memory answers one tick after the fetch strobe and that
  accumulator, data pointer and operand bytes are stable at the last tick.
*/
// What this block does
// - Short jump is opcode plus signed offset, reach -128..+127 from next instruction.
// - Long jump is three bytes; 16-bit target loaded whole into program counter.
// - Absolute jump: opcode carries target bits 10:8, second byte bits 7:0.
// - Absolute jump replaces low 11 bits, keeps upper 5 of incremented counter.
// - Indexed jump loads program counter with data pointer plus accumulator.
// - Long call takes a full 16-bit target anywhere in 64K.
// - Absolute call uses 11-bit target within the same 2K block.
// - Return resumes at the instruction after the entering call.
// - Interrupt return acts as return and signals interrupt completion.
// - All conditional branches use signed offset byte, -128..+127.
// - Zero-test branches examine the accumulator directly, equal or unequal zero.
// - Decrement-and-branch decrements operand, branches when result nonzero.
// - Compare-and-branch branches only when the two bytes differ.
// - Compare sets carry when first below second unsigned, else clears.
// - Machine cycle is six states of two oscillator periods each.
// - Each state has a first-phase and second-phase half, one period each.
// - Two fetches per cycle, none in a data move's second; unneeded byte discarded, counter not advanced.
// - One-cycle op: opcode latched S1, second fetch S4, done end of S6.
// - External data move takes two cycles, no fetch in the second.
// - Fetch and execute timing identical for internal and external code.
// - External code memory sees the read strobe twice per machine cycle, except none in a data move's second cycle.
// - Taken relative branch adds signed offset to counter past the instruction.
`timescale 1ns/10ps
`default_nettype none

module branch_cycle_unit (
  input  wire logic                   sys_clk,        // Oscillator clock, 10 MHz
  input  wire logic                   rstn,           // Async reset, active low
  input  wire logic                   code_external,  // 1: code memory is off chip
  input  wire logic [7:0]             code_data,      // Code byte, one tick after fetch
  input  wire mcu_ctrl_pkg::operand_s operands,       // Datapath operands
  output logic [15:0]                 code_addr,      // Fetch address
  output logic                        code_fetch,     // Fetch slot pulse, any memory
  output logic                        code_memory_read_strobe, // External read strobe pulse
  output logic                        xdata_cycle,    // Bus lent to external data move
  output mcu_ctrl_pkg::result_s       result,         // Write-back pulses
  output mcu_ctrl_pkg::timing_s       timing,         // Current state and phase
  output logic [7:0]                  opcode          // Instruction register
);
  import mcu_ctrl_pkg::*;

  typedef struct packed {
    logic [15:0]                  pc;
    logic [7:0]                   ir;
    logic [7:0]                   b2;
    logic [7:0]                   b3;
    logic                         cyc;    // 0 first, 1 second machine cycle
    logic [2:0]                   sp;
    logic [STACK_DEPTH-1:0][15:0] stack;  // Return addresses
    result_s                      res;
  } ctrl_s;

  ctrl_s q;
  ctrl_s d;
  kind_e kind;
  logic  fetch_slot;
  logic  fetch_allowed;

  function automatic kind_e decode(input logic [7:0] op);
    kind_e k;
    k = K_OTHER;
    if (op[4:0] == OP_ABS_JUMP_LOW) begin
      k = K_ABS_JUMP;
    end else if (op[4:0] == OP_ABS_CALL_LOW) begin
      k = K_ABS_CALL;
    end else if (op == OP_NO_OPERATION) begin
      k = K_NO_OPERATION;
    end else if (op == OP_SHORT_JUMP) begin
      k = K_SHORT_JUMP;
    end else if (op == OP_LONG_JUMP) begin
      k = K_LONG_JUMP;
    end else if (op == OP_LONG_CALL) begin
      k = K_LONG_CALL;
    end else if (op == OP_SUB_RETURN) begin
      k = K_SUB_RETURN;
    end else if (op == OP_INT_RETURN) begin
      k = K_INT_RETURN;
    end else if (op == OP_ACC_ZERO) begin
      k = K_ACC_ZERO;
    end else if (op == OP_ACC_NONZERO) begin
      k = K_ACC_NONZERO;
    end else if (op == OP_INDEXED_JUMP) begin
      k = K_INDEXED_JUMP;
    end else if (op == OP_DECREMENT_BR) begin
      k = K_DECREMENT_BR;
    end else if (op == OP_COMPARE_BR) begin
      k = K_COMPARE_BR;
    end else if (op == OP_XDATA_MOVE) begin
      k = K_XDATA_MOVE;
    end
    return k;
  endfunction

  // Bytes the instruction occupies in code memory
  function automatic logic [1:0] byte_len(input kind_e k);
    logic [1:0] n;
    n = 2'd1;
    case (k)
      K_LONG_JUMP, K_LONG_CALL: begin
        n = 2'd3;
      end
      K_SHORT_JUMP, K_ABS_JUMP, K_ABS_CALL, K_ACC_ZERO, K_ACC_NONZERO,
      K_DECREMENT_BR, K_COMPARE_BR: begin
        n = 2'd2;
      end
      default: begin
        n = 2'd1;
      end
    endcase
    return n;
  endfunction

  function automatic logic two_cycles(input kind_e k);
    return (k != K_NO_OPERATION) && (k != K_OTHER);
  endfunction

  // Signed offset added to a counter already past the instruction
  function automatic logic [15:0] rel_target(input logic [15:0] pc, input logic [7:0] off);
    return pc + {{8{off[7]}}, off};
  endfunction

  cycle_timing_gen u_timing (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .timing  (timing)
  );

  assign kind = decode(q.ir);

  // Only the second cycle of an external data move skips its fetches
  assign fetch_allowed = !(kind == K_XDATA_MOVE && q.cyc);
  // Held off in reset: tick 0 is forced there and the external strobe must stay quiet
  assign fetch_slot = rstn && (timing.tick == FETCH1_TICK || timing.tick == FETCH2_TICK) &&
                      fetch_allowed;

  always_comb begin
    logic        taken;
    logic [7:0]  dec;
    logic [15:0] target;
    logic [2:0]  sp_dn;
    taken  = 1'b0;
    dec    = operands.opnd_a - 8'h01;
    target = q.pc;
    sp_dn  = q.sp - 3'h1;
    d      = q;
    d.res  = '0;

    // Opcode sampled in S1; slot logic is the same for either memory
    if (timing.tick == SAMPLE1_TICK && !q.cyc) begin
      d.ir = code_data;
      d.pc = q.pc + 16'h0001;
    end else if (timing.tick == SAMPLE2_TICK && !q.cyc && byte_len(kind) >= 2'd2) begin
      d.b2 = code_data;
      d.pc = q.pc + 16'h0001;
    end else if (timing.tick == SAMPLE1_TICK && q.cyc && byte_len(kind) == 2'd3) begin
      d.b3 = code_data;
      d.pc = q.pc + 16'h0001;
    end

    // Execution completes at the end of S6 of the final machine cycle
    if (timing.tick == LAST_TICK) begin
      if (two_cycles(kind) && !q.cyc) begin
        d.cyc = 1'b1;
      end else begin
        d.cyc = 1'b0;
        case (kind)
          K_SHORT_JUMP: begin
            d.pc = rel_target(q.pc, q.b2);
          end
          K_LONG_JUMP: begin
            d.pc = {q.b2, q.b3};
          end
          K_ABS_JUMP: begin
            d.pc = {q.pc[15:11], q.ir[7:5], q.b2};
          end
          K_INDEXED_JUMP: begin
            d.pc = operands.data_pointer_register + {8'h00, operands.acc};
          end
          K_LONG_CALL: begin
            d.stack[q.sp] = q.pc;
            d.sp = q.sp + 3'h1;
            d.pc = {q.b2, q.b3};
          end
          K_ABS_CALL: begin
            d.stack[q.sp] = q.pc;
            d.sp = q.sp + 3'h1;
            d.pc = {q.pc[15:11], q.ir[7:5], q.b2};
          end
          K_SUB_RETURN: begin
            d.sp = sp_dn;
            d.pc = q.stack[sp_dn];
          end
          K_INT_RETURN: begin
            d.sp = sp_dn;
            d.pc = q.stack[sp_dn];
            d.res.irq_done = 1'b1;
          end
          K_ACC_ZERO: begin
            taken = (operands.acc == 8'h00);
          end
          K_ACC_NONZERO: begin
            taken = (operands.acc != 8'h00);
          end
          K_DECREMENT_BR: begin
            d.res.dec_we    = 1'b1;
            d.res.dec_value = dec;
            taken = (dec != 8'h00);
          end
          K_COMPARE_BR: begin
            d.res.carry_we = 1'b1;
            d.res.carry    = (operands.opnd_a < operands.opnd_b);
            taken = (operands.opnd_a != operands.opnd_b);
          end
          default: begin
            taken = 1'b0;
          end
        endcase
        if (taken) begin
          target = rel_target(q.pc, q.b2);
          d.pc = target;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      q       <= '0;
      q.pc    <= PC_RESET;
      q.ir    <= OP_NO_OPERATION;
      q.sp    <= SP_RESET;
    end else begin
      q <= d;
    end
  end

  // Strobe only gates the pin; timing stays the same when code is on chip
  assign code_addr      = q.pc;
  assign code_fetch     = fetch_slot;
  assign code_memory_read_strobe = fetch_slot && code_external;
  assign xdata_cycle    = (kind == K_XDATA_MOVE) && q.cyc;
  assign result         = q.res;
  assign opcode         = q.ir;

endmodule

`default_nettype wire

// ===== tb/branch_cycle_unit_properties.sv
/*
  Port checker for branch_cycle_unit: slot timing, strobes, write-back.
  Assumes it is bound to every instance of the unit.
*/
`timescale 1ns/10ps
`default_nettype none

module branch_cycle_unit_properties (
  input wire logic                   sys_clk,        // Clock
  input wire logic                   rstn,           // Async reset
  input wire logic                   code_external,  // Off-chip code
  input wire mcu_ctrl_pkg::operand_s operands,       // Operands
  input wire logic [15:0]            code_addr,      // Fetch address
  input wire logic                   code_fetch,     // Fetch slot
  input wire logic                   code_memory_read_strobe, // Read strobe
  input wire logic                   xdata_cycle,    // Bus lent
  input wire mcu_ctrl_pkg::result_s  result,         // Write-back
  input wire mcu_ctrl_pkg::timing_s  timing          // Timing
);
  import mcu_ctrl_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_fetch_slots: assert property (code_fetch |-> timing.tick inside {4'h0, 4'h6})
    else $error("fetch outside its slot");
  a_fetch_both: assert property (
    timing.tick inside {4'h0, 4'h6} && !xdata_cycle |-> code_fetch)
    else $error("fetch slot skipped");
  a_strobe_gate: assert property (
    code_memory_read_strobe == (code_fetch && code_external))
    else $error("read strobe mismatch");
  a_tick_wrap: assert property (timing.tick == 4'hb |=> timing.tick == 4'h0)
    else $error("cycle not twelve ticks");
  a_state_map: assert property (
    timing.state == 3'(timing.tick >> 1) + 3'h1 && timing.phase1 == !timing.tick[0])
    else $error("state or phase wrong");
  a_xdata_start: assert property (
    $rose(xdata_cycle) |-> timing.tick == 4'h0 && !code_fetch)
    else $error("bus loan misaligned");
  a_xdata_end: assert property (xdata_cycle && timing.tick == 4'hb |=> !xdata_cycle)
    else $error("bus loan too long");
  a_pulse_once: assert property (
    (result.dec_we || result.carry_we || result.irq_done) |->
      timing.tick == 4'h0 ##1 !(result.dec_we || result.carry_we || result.irq_done))
    else $error("write-back pulse wrong");
  a_dec_value: assert property (
    result.dec_we |-> result.dec_value == $past(operands.opnd_a) - 8'h1)
    else $error("decrement value wrong");
  a_carry_cmp: assert property (
    result.carry_we |-> result.carry == ($past(operands.opnd_a) < $past(operands.opnd_b)))
    else $error("compare carry wrong");
  a_pc_moves: assert property (
    $changed(code_addr) |-> timing.tick inside {4'h0, 4'h2, 4'h8})
    else $error("counter moved off slot");
endmodule

bind branch_cycle_unit branch_cycle_unit_properties chk (.sys_clk(sys_clk), .rstn(rstn),
  .code_external(code_external), .operands(operands), .code_addr(code_addr),
  .code_fetch(code_fetch), .code_memory_read_strobe(code_memory_read_strobe),
  .xdata_cycle(xdata_cycle), .result(result), .timing(timing));

`default_nettype wire

// ===== tb/code_memory_model.sv
/*
  Code memory partner: answers a fetch one tick later, 64K bytes of no_operation.
  Assumes the bench loads bytes into mem by hierarchical reference.
*/
`timescale 1ns/10ps
`default_nettype none

module code_memory_model (
  input  wire logic        sys_clk,    // Clock
  input  wire logic [15:0] code_addr,  // Fetch address
  input  wire logic        code_fetch, // Fetch slot
  output var  logic [7:0]  code_data   // Code byte
);
  logic [7:0] mem [65536];

  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    code_data = 8'h00;
  end

  // Outside the answer tick the bus flips so a stale byte is never mistaken for data
  always @(posedge sys_clk) begin
    code_data <= code_fetch ? mem[code_addr] : ~code_data;
  end
endmodule

`default_nettype wire

// ===== tb/tb.sv
/*
  Testbench for branch_cycle_unit: one task per scenario.
  Assumes the unit restarts from address 0000 after each reset.
*/
`timescale 1ns/10ps
`default_nettype none

module tb;
  import mcu_ctrl_pkg::*;
  logic        sys_clk, rstn, code_external, code_fetch, code_memory_read_strobe, xdata_cycle;
  logic [7:0]  code_data, opcode;
  logic [15:0] code_addr;
  operand_s    operands;
  result_s     result;
  timing_s     timing;
  int          n_errors, n_compared, n_strobe, n_fetch;

  branch_cycle_unit DUT (.sys_clk(sys_clk), .rstn(rstn), .code_external(code_external),
    .code_data(code_data), .operands(operands), .code_addr(code_addr), .code_fetch(code_fetch),
    .code_memory_read_strobe(code_memory_read_strobe), .xdata_cycle(xdata_cycle),
    .result(result), .timing(timing), .opcode(opcode));
  code_memory_model mem_i (.sys_clk(sys_clk), .code_addr(code_addr), .code_fetch(code_fetch),
    .code_data(code_data));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    n_strobe += int'(code_memory_read_strobe);
    n_fetch += int'(code_fetch);
  end

  task automatic check(input string name, input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic put(input logic [15:0] a, input logic [7:0] b0, b1, b2);
    mem_i.mem[a] = b0;
    mem_i.mem[16'(a + 1)] = b1;
    mem_i.mem[16'(a + 2)] = b2;
  endtask

  task automatic restart();
    @(posedge sys_clk);
    #10 rstn = 1'b0;
    @(posedge sys_clk);
    #10 rstn = 1'b1;
  endtask

  // Advance to tick 0 of the n-th following machine cycle
  task automatic cyc(input int n);
    int k;
    repeat (n) begin
      k = 0;
      do begin
        @(posedge sys_clk);
        #10 k++;
      end while (timing.tick !== 4'h0 && k < 20);
      if (k >= 20) n_errors++;
    end
  endtask

  task automatic t_jumps();
    put(16'h0000, OP_LONG_JUMP, 8'h27, 8'hfe);
    put(16'h27fe, 8'ha1, 8'h55, 8'h00);
    put(16'h2d55, OP_SHORT_JUMP, 8'h80, 8'h00);
    restart();
    cyc(2);
    check("long_jump", code_addr, 16'h27fe);
    cyc(2);
    check("abs_jump", code_addr, 16'h2d55);
    cyc(2);
    check("short_jump", code_addr, 16'h2cd7);
  endtask

  task automatic t_calls();
    put(16'h0000, OP_LONG_CALL, 8'h40, 8'h00);
    put(16'h4000, 8'h71, 8'h20, 8'h00);
    put(16'h4002, OP_INT_RETURN, 8'h00, 8'h00);
    put(16'h4320, OP_SUB_RETURN, 8'h00, 8'h00);
    restart();
    cyc(2);
    check("long_call", code_addr, 16'h4000);
    cyc(2);
    check("abs_call", code_addr, 16'h4320);
    cyc(2);
    check("return", code_addr, 16'h4002);
    cyc(2);
    check("int_return", code_addr, 16'h0003);
    check("irq_done", {15'h0, result.irq_done}, 16'h0001);
  endtask

  task automatic t_indexed();
    operands = '{acc: 8'h20, data_pointer_register: 16'h12f0, opnd_a: 8'h00, opnd_b: 8'h00};
    put(16'h0000, OP_INDEXED_JUMP, 8'h00, 8'h00);
    restart();
    cyc(2);
    check("indexed", code_addr, 16'h1310);
  endtask

  task automatic t_cond();
    logic [7:0] op [9] = '{OP_ACC_ZERO, OP_ACC_ZERO, OP_ACC_NONZERO, OP_ACC_NONZERO,
      OP_COMPARE_BR, OP_COMPARE_BR, OP_COMPARE_BR, OP_DECREMENT_BR, OP_DECREMENT_BR};
    logic [7:0] av [9] = '{8'h00, 8'h05, 8'h00, 8'h05, 8'h03, 8'h09, 8'h07, 8'h01, 8'h00};
    logic [7:0] bv [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h09, 8'h03, 8'h07, 8'h00, 8'h00};
    logic       tk;
    for (int i = 0; i < 9; i++) begin
      put(16'h0000, op[i], 8'hf0, 8'h00);
      operands = '{acc: av[i], data_pointer_register: 16'h0000, opnd_a: av[i], opnd_b: bv[i]};
      restart();
      cyc(2);
      tk = (op[i] == OP_ACC_ZERO) ? av[i] == 8'h00 : (op[i] == OP_ACC_NONZERO) ? av[i] != 8'h00 :
           (op[i] == OP_COMPARE_BR) ? av[i] != bv[i] : av[i] != 8'h01;
      check("branch", code_addr, tk ? 16'hfff2 : 16'h0002);
      if (op[i] == OP_COMPARE_BR)
        check("carry", {14'h0, result.carry_we, result.carry}, {15'h1, av[i] < bv[i]});
      if (op[i] == OP_DECREMENT_BR)
        check("dec", {7'h0, result.dec_we, result.dec_value}, {8'h1, av[i] - 8'h01});
    end
  endtask

  task automatic t_cycles();
    // Byte a5 decodes as no listed instruction and must run as a one-byte, one-cycle op
    put(16'h0000, OP_NO_OPERATION, OP_XDATA_MOVE, 8'ha5);
    for (int e = 1; e >= 0; e--) begin
      code_external = e[0];
      restart();
      n_strobe = 0;
      n_fetch = 0;
      cyc(1);
      check("idle_cycle", code_addr, 16'h0001);
      cyc(1);
      check("xdata_on", {15'h0, xdata_cycle}, 16'h0001);
      check("opcode_move", {8'h00, opcode}, {8'h00, OP_XDATA_MOVE});
      cyc(1);
      check("xdata_pc", code_addr, 16'h0002);
      check("xdata_off", {15'h0, xdata_cycle}, 16'h0000);
      check("fetches", 16'(n_fetch), 16'h0004);
      check("strobes", 16'(n_strobe), e ? 16'h0004 : 16'h0000);
      cyc(1);
      check("other_op", code_addr, 16'h0003);
      check("opcode_other", {8'h00, opcode}, 16'h00a5);
    end
  endtask

  task automatic print_verdict();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    rstn = 1'b0;
    code_external = 1'b1;
    operands = '0;
    repeat (16) @(posedge sys_clk);
    t_jumps();
    t_calls();
    t_indexed();
    t_cond();
    t_cycles();
    print_verdict();
  end

  // About four times the expected run
  initial begin
    #200000;
    n_errors++;
    print_verdict();
  end
endmodule

`default_nettype wire
